// *** verilog/oscc_pkg.sv ***
// Purpose: constants shared by the output switch cycle counter block
// Assumes: 50 MHz clock, two on/off control outputs
// Notes: counts are held in units of one hundred switching cycles
package oscc_pkg;

  // ==========================================================
  // widths and ranges
  localparam int unsigned OSCC_VAL_W = 14;
  localparam logic [13:0] OSCC_MON_MAX = 14'h270F;
  localparam logic [13:0] OSCC_MON_RESET = 14'h0000;
  localparam logic [6:0] OSCC_SUB_LAST = 7'h63;
  localparam int unsigned OSCC_SUB_W = 7;

  // ==========================================================
  // counter reset selector codes
  localparam logic [1:0] OSCC_RST_NONE = 2'h0;
  localparam logic [1:0] OSCC_RST_OUT1 = 2'h1;
  localparam logic [1:0] OSCC_RST_OUT2 = 2'h2;

  // ==========================================================
  // alarm routing selector codes
  localparam logic [1:0] OSCC_ROUTE_OFF = 2'h0;
  localparam logic [1:0] OSCC_ROUTE_ALM = 2'h1;
  localparam logic [1:0] OSCC_ROUTE_ALM_N = 2'h2;

  // ==========================================================
  // display alternation: 0.5 s phases
  localparam int unsigned OSCC_CLK_HZ = 50000000;
  localparam int unsigned OSCC_BLINK_MS = 500;
  localparam int unsigned OSCC_BLINK_CYC = OSCC_CLK_HZ / 1000 * OSCC_BLINK_MS;

endpackage : oscc_pkg

// *** verilog/oscc_channel.sv ***
// Purpose: one switching cycle counter with threshold alarm
// Assumes: sw_out is the synchronous state of the control output
// Notes: one ON/OFF cycle counts at the falling edge of the output
`timescale 1ns/100ps
`default_nettype none
module oscc_channel
  import oscc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sw_out,
  input wire logic onoff_type,
  input wire logic [13:0] threshold,
  input wire logic clear,
  input wire logic corrupt,
  output logic [13:0] monitor,
  output logic alarm
);

  // ==========================================================
  // edge detect
  logic sw_prev;
  logic cycle_done;
  logic [6:0] sub_count;
  logic [13:0] next_monitor;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sw_prev <= 1'b0;
    else
      sw_prev <= sw_out;
  end

  assign cycle_done = sw_prev && !sw_out && onoff_type && (threshold != 14'h0000);

  // ==========================================================
  // sub-counter and monitor
  always_comb
  begin
    next_monitor = monitor;
    if (cycle_done && sub_count == OSCC_SUB_LAST && monitor != OSCC_MON_MAX)
      next_monitor = monitor + 14'h0001;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sub_count <= '0;
    else if (clear)
      sub_count <= '0;
    else if (cycle_done)
      sub_count <= (sub_count == OSCC_SUB_LAST) ? 7'h00 : sub_count + 7'h01;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      monitor <= OSCC_MON_RESET;
    else if (clear)
      monitor <= OSCC_MON_RESET;
    else if (corrupt)
      monitor <= OSCC_MON_MAX;
    else
      monitor <= next_monitor;
  end

  // ==========================================================
  // alarm: sticky so corrupt-data alarm survives until reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      alarm <= 1'b0;
    // corrupt data alarms; set wins over clear
    else if (corrupt)
      alarm <= 1'b1;
    else if (clear)
      alarm <= 1'b0;
    else if (threshold != 14'h0000 && next_monitor > threshold)
      alarm <= 1'b1;
  end

endmodule : oscc_channel
`default_nettype wire

// *** verilog/oscc_top.sv ***
// Purpose: switching cycle counters for two control outputs, with alarm
// Assumes: all inputs synchronous to clk; settings held steady by the panel logic
// Notes: counter_reset_sel is sampled every cycle; hold it one cycle per reset
`timescale 1ns/100ps
`default_nettype none
module oscc_top
  import oscc_pkg::*;
#(
  parameter int unsigned BLINK_CYC = OSCC_BLINK_CYC
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic out1_state,
  input wire logic out2_state,
  input wire logic out1_onoff,
  input wire logic out2_onoff,
  input wire logic [13:0] out1_threshold,
  input wire logic [13:0] out2_threshold,
  input wire logic [1:0] counter_reset_sel,
  input wire logic out1_data_corrupt,
  input wire logic out2_data_corrupt,
  input wire logic [1:0] ctrl_route_sel,
  input wire logic [1:0] aux_route_sel,
  input wire logic pv_screen_active,
  output logic [13:0] out1_monitor,
  output logic [13:0] out2_monitor,
  output logic out1_alarm,
  output logic out2_alarm,
  output logic count_alarm,
  output logic monitor_visible,
  output logic ctrl_alarm_out,
  output logic aux_alarm_out,
  output logic count_alarm_indicator
);

  // ==========================================================
  // reset selector decode
  logic clr1;
  logic clr2;
  logic [13:0] mon1;
  logic [13:0] mon2;
  logic alm1;
  logic alm2;
  logic alm_any;
  logic [31:0] blink_cnt;
  logic blink_phase;

  assign clr1 = (counter_reset_sel == OSCC_RST_OUT1);
  assign clr2 = (counter_reset_sel == OSCC_RST_OUT2);

  // ==========================================================
  // channels
  oscc_channel u_ch1 (
    .clk(clk),
    .reset_n(reset_n),
    .sw_out(out1_state),
    .onoff_type(out1_onoff),
    .threshold(out1_threshold),
    .clear(clr1),
    .corrupt(out1_data_corrupt),
    .monitor(mon1),
    .alarm(alm1)
  );

  oscc_channel u_ch2 (
    .clk(clk),
    .reset_n(reset_n),
    .sw_out(out2_state),
    .onoff_type(out2_onoff),
    .threshold(out2_threshold),
    .clear(clr2),
    .corrupt(out2_data_corrupt),
    .monitor(mon2),
    .alarm(alm2)
  );

  assign alm_any = alm1 | alm2;

  // ==========================================================
  // registered status outputs
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out1_monitor <= OSCC_MON_RESET;
      out2_monitor <= OSCC_MON_RESET;
      out1_alarm <= 1'b0;
      out2_alarm <= 1'b0;
      count_alarm <= 1'b0;
    end
    else
    begin
      out1_monitor <= mon1;
      out2_monitor <= mon2;
      out1_alarm <= alm1;
      out2_alarm <= alm2;
      count_alarm <= alm_any;
    end
  end

  // monitor hidden when both outputs unused or both linear
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      monitor_visible <= 1'b0;
    else
      monitor_visible <= ((out1_threshold != 14'h0000) || (out2_threshold != 14'h0000))
                         && (out1_onoff || out2_onoff);
  end

  // ==========================================================
  // alarm routing to outputs
  function automatic logic route(input logic [1:0] sel, input logic a);
    route = (sel == OSCC_ROUTE_ALM) ? a : (sel == OSCC_ROUTE_ALM_N) ? !a : 1'b0;
  endfunction : route

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_alarm_out <= 1'b0;
      aux_alarm_out <= 1'b0;
    end
    else
    begin
      ctrl_alarm_out <= route(ctrl_route_sel, alm_any);
      aux_alarm_out <= route(aux_route_sel, alm_any);
    end
  end

  // ==========================================================
  // display alternation; timer idles without an alarm to save toggling
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end
    else if (!alm_any)
    begin
      blink_cnt <= '0;
      blink_phase <= 1'b0;
    end
    else if (blink_cnt >= BLINK_CYC - 1)
    begin
      blink_cnt <= '0;
      blink_phase <= !blink_phase;
    end
    else
      blink_cnt <= blink_cnt + 32'h00000001;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_alarm_indicator <= 1'b0;
    else
      count_alarm_indicator <= alm_any && pv_screen_active && blink_phase;
  end

endmodule : oscc_top
`default_nettype wire

// *** sim/oscc_asserts.sv ***
// Purpose: port checks for oscc_top
// Assumes: settings held steady
// Notes: bound at the file foot
`timescale 1ns/100ps
`default_nettype none
module oscc_asserts
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] counter_reset_sel,
  input wire logic out1_data_corrupt,
  input wire logic out2_data_corrupt,
  input wire logic [13:0] out1_monitor,
  input wire logic [13:0] out2_monitor,
  input wire logic out1_alarm,
  input wire logic out2_alarm,
  input wire logic count_alarm
);
  // ========
  // all checks on clk, quiet in reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_or;
    count_alarm == (out1_alarm || out2_alarm);
  endproperty
  a_or: assert property (p_or) else $error("combined alarm");
  property p_clr1;
    counter_reset_sel == 2'h1 && !out1_data_corrupt
      |-> ##[1:2] out1_monitor == 14'h0000 && !out1_alarm;
  endproperty
  a_clr1: assert property (p_clr1) else $error("clear 1");
  property p_clr2;
    counter_reset_sel == 2'h2 && !out2_data_corrupt
      |-> ##[1:2] out2_monitor == 14'h0000 && !out2_alarm;
  endproperty
  a_clr2: assert property (p_clr2) else $error("clear 2");
  property p_bad2;
    out2_data_corrupt && counter_reset_sel == 2'h0
      |-> ##[1:2] out2_monitor == 14'h270F && out2_alarm;
  endproperty
  a_bad2: assert property (p_bad2) else $error("corrupt 2");
  property p_bad1;
    out1_data_corrupt && counter_reset_sel == 2'h0
      |-> ##[1:2] out1_monitor == 14'h270F && out1_alarm;
  endproperty
  a_bad1: assert property (p_bad1) else $error("corrupt 1");
  // alarm holds until its own clear has had time to land
  property p_stk1;
    out1_alarm && counter_reset_sel != 2'h1 && $past(counter_reset_sel) != 2'h1 |=> out1_alarm;
  endproperty
  a_stk1: assert property (p_stk1) else $error("alarm 1 dropped");
  property p_stk2;
    out2_alarm && counter_reset_sel != 2'h2 && $past(counter_reset_sel) != 2'h2 |=> out2_alarm;
  endproperty
  a_stk2: assert property (p_stk2) else $error("alarm 2 dropped");
  property p_max1;
    out1_monitor <= 14'h270F;
  endproperty
  a_max1: assert property (p_max1) else $error("monitor 1 range");
  property p_max2;
    $changed(out2_monitor) |-> out2_monitor <= 14'h270F;
  endproperty
  a_max2: assert property (p_max2) else $error("monitor 2 range");
endmodule : oscc_asserts
bind oscc_top oscc_asserts u_chk (.clk, .reset_n, .counter_reset_sel, .out1_data_corrupt,
  .out2_data_corrupt, .out1_monitor, .out2_monitor, .out1_alarm, .out2_alarm, .count_alarm);
`default_nettype wire

// *** sim/oscc_relay.sv ***
// Purpose: relay or SSR drive on one output
// Assumes: run held by bench
// Notes: slow mode gives 4-cycle phases
`timescale 1ns/100ps
`default_nettype none
module oscc_relay
(
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  output logic state = 1'h0
);
  logic [1:0] cnt = 2'h0;
  // ========
  // on/off output
  // rests low when stopped, like a released contact
  always @(posedge clk)
  begin
    if (run || state)
    begin
      cnt <= cnt + 2'h1;
      if (!slow || cnt == 2'h3)
        state <= ~state;
    end
  end
endmodule : oscc_relay
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: bench for oscc_top
// Assumes: relay models drive outputs
// Notes: reference counts falls itself
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, reset_n = 1'h0, o1, o2, on1 = 1'h1, on2 = 1'h1, c2 = 1'h0, pv = 1'h0;
  logic r1 = 1'h0, r2 = 1'h0, sl = 1'h0, p1 = 1'h0, p2 = 1'h0, a1, a2, ca, vis, co, ao, ind;
  logic [13:0] t1 = 14'h0000, t2 = 14'h0000, m1, m2;
  logic [1:0] sel = 2'h0, cr = 2'h0, ar = 2'h0;
  logic c1 = 1'h0;
  logic [31:0] rs = 32'hBEA5;
  int miscompares = 0, num_checks = 0, k, sub[2], mon[2], alm[2];
  // ========
  // partners and unit
  oscc_relay rl1 (.clk, .run(r1), .slow(sl), .state(o1));
  oscc_relay rl2 (.clk, .run(r2), .slow(sl), .state(o2));
  oscc_top #(.BLINK_CYC(4)) uut (.clk, .reset_n, .out1_state(o1), .out2_state(o2),
    .out1_onoff(on1), .out2_onoff(on2), .out1_threshold(t1), .out2_threshold(t2),
    .counter_reset_sel(sel), .out1_data_corrupt(c1), .out2_data_corrupt(c2),
    .ctrl_route_sel(cr), .aux_route_sel(ar), .pv_screen_active(pv), .out1_monitor(m1),
    .out2_monitor(m2), .out1_alarm(a1), .out2_alarm(a2), .count_alarm(ca),
    .monitor_visible(vis), .ctrl_alarm_out(co), .aux_alarm_out(ao),
    .count_alarm_indicator(ind));
  initial forever #10 clk = ~clk;
  // reference: fall count, hundreds, sticky alarm
  always @(posedge clk)
  begin
    p1 <= o1;
    p2 <= o2;
    step(0, p1 & ~o1 & on1, t1, sel == 2'h1, c1);
    step(1, p2 & ~o2 & on2, t2, sel == 2'h2, c2);
  end
  task automatic step(int i, logic f, logic [13:0] t, logic clr, logic bad);
    if (clr)
    begin
      sub[i] = 0;
      mon[i] = 0;
      alm[i] = 0;
    end
    else if (f && t != 0)
    begin
      sub[i] = sub[i] + 1;
      if (sub[i] == 100)
      begin
        sub[i] = 0;
        mon[i] = (mon[i] < 9999) ? mon[i] + 1 : 9999;
      end
    end
    if (bad && !clr)
      mon[i] = 9999;
    alm[i] = alm[i] | bad | (t != 0 && mon[i] > t);
  endtask : step
  function automatic logic rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[0];
  endfunction : rnd
  task automatic chk(logic [13:0] s, logic [13:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic cycles(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cycles
  // random pace, then idle long enough to settle
  task automatic spin(int n);
    sl = rnd();
    r1 = 1'h1;
    r2 = 1'h1;
    cycles(n);
    r1 = 1'h0;
    r2 = 1'h0;
    cycles(12);
  endtask : spin
  task automatic verify;
    chk(m1, 14'(mon[0]));
    chk(m2, 14'(mon[1]));
    chk(a1, 14'(alm[0]));
    chk(a2, 14'(alm[1]));
    chk(ca, 14'(alm[0] | alm[1]));
  endtask : verify
  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial
  begin
    #500000;
    miscompares++;
    stop_test;
  end
  // ========
  // main sequence
  initial
  begin
    cycles(10);
    reset_n = 1'h1;
    cycles(2);
    t1 = 14'h0001;
    pv = 1'h1;
    spin(2400);
    verify;
    chk(vis, 14'h1);
    for (k = 0; k < 30 && ind !== 1'h1; k++)
      cycles(1);
    chk(ind, 14'h1);
    for (k = 0; k < 30 && ind !== 1'h0; k++)
      cycles(1);
    chk(ind, 14'h0);
    for (k = 0; k < 4; k++)
    begin
      cr = 2'(k);
      ar = 2'(3 - k);
      cycles(3);
      chk(co, 14'(k == 1));
      chk(ao, 14'(k == 2));
    end
    on2 = 1'h0;
    t2 = 14'h0005;
    pv = rnd();
    spin(600);
    verify;
    on2 = 1'h1;
    spin(1200);
    verify;
    c1 = 1'h1;
    c2 = 1'h1;
    cycles(1);
    c1 = 1'h0;
    c2 = 1'h0;
    cycles(3);
    verify;
    // counting on top of a forced maximum must not wrap
    spin(400);
    verify;
    for (k = 1; k < 3; k++)
    begin
      sel = 2'(k);
      cycles(1);
      sel = 2'h0;
      cycles(3);
      verify;
    end
    on1 = 1'h0;
    on2 = 1'h0;
    cycles(3);
    chk(vis, 14'h0);
    on1 = 1'h1;
    on2 = 1'h1;
    t1 = 14'h0000;
    t2 = 14'h0000;
    // inverted route only shows itself with no alarm standing
    cr = 2'h2;
    ar = 2'h1;
    cycles(3);
    chk(vis, 14'h0);
    chk(co, 14'h1);
    chk(ao, 14'h0);
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
